//--- rtl/edge_find.sv
`timescale 1ns/1ps
// =======================================================
// rise and fall detect on a synchronised clock level
module edge_find (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic last;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            last <= 1'b0;
        else
            last <= level;
    end

    assign rise = level && !last;
    assign fall = !level && last;
endmodule

//--- rtl/parallel_port_status.sv
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module parallel_port_status
    import ppcfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic collision,
    input wire logic rx_comma,
    input wire logic rx_clock,
    input wire logic ref_clock_125,
    input wire logic col_i,
    output logic col_o,
    output logic col_oe,
    input wire logic crs_i,
    output logic crs_o,
    output logic crs_oe,
    input wire logic rx_dv_i,
    input wire logic txclk_i,
    output logic txclk_o,
    output logic txclk_oe,
    input wire logic gtxclk,
    input wire logic [7:0] txd,
    output logic [7:0] tx_data,
    output logic tx_valid
);
    // =======================================================
    // pin synchronisers
    logic [3:0] strap_s;
    logic [3:0] clk_s;
    logic [7:0] txd_s;
    logic rx_comma_s;
    logic txclk_s;
    logic gtx_s;
    logic rxclk_s;
    logic clk125_s;

    sync2 #(.W(4)) u_sync_strap (
        .aclk(aclk),
        .async_in({txclk_i, rx_dv_i, crs_i, col_i}),
        .sync_out(strap_s)
    );

    sync2 #(.W(4)) u_sync_clk (
        .aclk(aclk),
        .async_in({ref_clock_125, rx_clock, gtxclk, rx_comma}),
        .sync_out(clk_s)
    );

    sync2 #(.W(8)) u_sync_txd (
        .aclk(aclk),
        .async_in(txd),
        .sync_out(txd_s)
    );

    assign rx_comma_s = clk_s[0];
    assign gtx_s = clk_s[1];
    assign rxclk_s = clk_s[2];
    assign clk125_s = clk_s[3];
    assign txclk_s = strap_s[3];

    logic gtx_rise;
    logic gtx_fall;
    logic rx_rise;
    logic rx_fall;

    edge_find u_edge_gtx (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(gtx_s),
        .rise(gtx_rise),
        .fall(gtx_fall)
    );

    edge_find u_edge_rx (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(rxclk_s),
        .rise(rx_rise),
        .fall(rx_fall)
    );

    // =======================================================
    // strap capture
    // taken on the first edge after release, from pins seen during reset
    logic strap_done;
    logic [3:0] strap;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            strap_done <= 1'b0;
            strap <= 4'h0;
        end
        else if (!strap_done)
        begin
            strap_done <= 1'b1;
            strap <= strap_s;
        end
    end

    // =======================================================
    // configuration registers
    logic loopback_enable;
    logic collision_test;
    logic [2:0] mode;
    logic ten_bit_two_clock_select;
    logic clock_out_enable;
    logic port_role_select;
    logic speed_10;

    logic is_mii;
    logic is_gmii;
    logic is_rgmii;
    logic is_tbi;
    logic is_rtbi;
    logic col_mode;
    logic ten_bit_mode;
    logic two_clock_eff;
    logic two_clock_mode;
    logic clock_out_eff;

    assign is_mii = (mode == MODE_MII);
    assign is_gmii = (mode == MODE_GMII);
    assign is_rgmii = (mode == MODE_RGMII);
    assign is_tbi = (mode == MODE_TBI);
    assign is_rtbi = (mode == MODE_RTBI);
    assign col_mode = is_mii || is_gmii || is_rgmii;
    assign ten_bit_mode = is_tbi || is_rtbi;
    assign two_clock_eff = ten_bit_two_clock_select || strap[2];
    assign two_clock_mode = is_tbi && two_clock_eff;
    assign clock_out_eff = clock_out_enable || strap[3];

    // =======================================================
    // collision and carrier / comma pins
    logic forced_low;
    logic comma_tick;
    logic next_col;
    logic next_crs;

    assign forced_low = loopback_enable && !collision_test;
    // collision test with loopback reports own transmission as collision
    assign next_col = forced_low ? 1'b0 : (loopback_enable ? tx_active : collision);
    assign comma_tick = rx_rise || (two_clock_mode && rx_fall);
    assign next_crs = ten_bit_mode ? (comma_tick ? rx_comma_s : crs_o) : (tx_active || rx_active);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            col_o <= 1'b0;
            crs_o <= 1'b0;
        end
        else
        begin
            col_o <= next_col;
            crs_o <= next_crs;
        end
    end

    assign col_oe = strap_done && col_mode;
    assign crs_oe = strap_done;

    // =======================================================
    // transmit clock pin
    logic [DIV_W-1:0] div_cnt;
    logic [DIV_W-1:0] div_last;
    logic mii_clk;

    assign div_last = speed_10 ? DIV_W'(HALF_10_CYCLES - 1) : DIV_W'(HALF_100_CYCLES - 1);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !is_mii || port_role_select)
        begin
            div_cnt <= '0;
            mii_clk <= 1'b0;
        end
        else if (div_cnt >= div_last)
        begin
            div_cnt <= '0;
            mii_clk <= !mii_clk;
        end
        else
            div_cnt <= div_cnt + DIV_W'(1);
    end

    // outside mii the pin clocks are sampled copies, good only for slow bench clocks
    assign txclk_o = is_mii ? mii_clk : (two_clock_mode ? !rxclk_s : clk125_s);
    assign txclk_oe = strap_done && (is_mii ? !port_role_select : (two_clock_mode || clock_out_eff));

    // =======================================================
    // transmit data capture
    logic [3:0] low_nibble;
    logic gmii_take;
    logic rgmii_low;
    logic rgmii_high;

    assign gmii_take = is_gmii && gtx_rise;
    assign rgmii_low = is_rgmii && !speed_10 && gtx_rise;
    assign rgmii_high = is_rgmii && !speed_10 && gtx_fall;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            low_nibble <= 4'h0;
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
        end
        else
        begin
            tx_valid <= gmii_take || rgmii_high;
            if (rgmii_low)
                low_nibble <= txd_s[3:0];
            if (gmii_take)
                tx_data <= txd_s;
            else if (rgmii_high)
                tx_data <= {txd_s[3:0], low_nibble};
        end
    end

    // =======================================================
    // axi4-lite slave
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_bmc;
    logic wr_cfg;
    logic wr_hit;
    logic [31:0] rd_mux;
    logic rd_hit;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_bmc = do_write && (aw_addr == ADDR_BASIC_MODE_CONTROL) && w_strb[0];
    assign wr_cfg = do_write && (aw_addr == ADDR_PARALLEL_PORT_CONFIG) && w_strb[0];
    assign wr_hit = (aw_addr == ADDR_BASIC_MODE_CONTROL) || (aw_addr == ADDR_PARALLEL_PORT_CONFIG);

    assign rd_hit = (s_axi_araddr == ADDR_BASIC_MODE_CONTROL) || (s_axi_araddr == ADDR_PARALLEL_PORT_CONFIG)
        || (s_axi_araddr == ADDR_STATUS) || (s_axi_araddr == ADDR_TX_DATA);
    assign rd_mux = (s_axi_araddr == ADDR_BASIC_MODE_CONTROL) ? {30'h0, collision_test, loopback_enable}
        : (s_axi_araddr == ADDR_PARALLEL_PORT_CONFIG)
            ? {24'h0, speed_10, port_role_select, clock_out_enable, ten_bit_two_clock_select, 1'b0, mode}
        : (s_axi_araddr == ADDR_STATUS) ? {24'h0, two_clock_eff, txclk_s, strap, crs_o, col_o}
        : (s_axi_araddr == ADDR_TX_DATA) ? {24'h0, tx_data}
        : 32'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            loopback_enable <= RESET_OFF;
            collision_test <= RESET_OFF;
            mode <= MODE_RESET;
            ten_bit_two_clock_select <= RESET_OFF;
            clock_out_enable <= RESET_OFF;
            port_role_select <= RESET_OFF;
            speed_10 <= RESET_OFF;
        end
        else if (wr_bmc)
        begin
            loopback_enable <= w_data[BMC_LOOPBACK_BIT];
            collision_test <= w_data[BMC_COL_TEST_BIT];
        end
        else if (wr_cfg)
        begin
            mode <= w_data[CFG_MODE_LSB +: CFG_MODE_W];
            ten_bit_two_clock_select <= w_data[CFG_TWO_CLOCK_BIT];
            clock_out_enable <= w_data[CFG_CLOCK_OUT_BIT];
            port_role_select <= w_data[CFG_ROLE_BIT];
            speed_10 <= w_data[CFG_SPEED10_BIT];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // =======================================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_col_forced_low: assert property ($past(forced_low) |-> !col_o) else $error("col not held low");
    a_col_follows: assert property ($past(!loopback_enable && collision) |-> col_o) else $error("col missed");
    a_col_tristate: assert property (ten_bit_mode |-> !col_oe) else $error("col driven in ten-bit mode");
    a_crs_active: assert property ($past(!ten_bit_mode && (tx_active || rx_active)) |-> crs_o)
        else $error("carrier sense missed");
    a_comma_update: assert property (ten_bit_mode && comma_tick ##1 ten_bit_mode |-> crs_o == $past(rx_comma_s))
        else $error("comma not updated");
    a_comma_hold: assert property (ten_bit_mode && !two_clock_mode && rx_fall |=> $stable(crs_o))
        else $error("comma moved on falling edge");
    a_comma_second: assert property (two_clock_mode && rx_fall ##1 two_clock_mode |-> crs_o == $past(rx_comma_s))
        else $error("comma missed second clock");
    a_pins_reset: assert property (!strap_done |-> !col_oe && !crs_oe && !txclk_oe)
        else $error("pin driven before straps taken");
    a_dte_input: assert property (is_mii && port_role_select |-> !txclk_oe) else $error("txclk driven in dte");
    a_two_clock_out: assert property (strap_done && two_clock_mode |-> txclk_oe && (txclk_o == !rxclk_s))
        else $error("second receive clock wrong");
    a_clock_out: assert property (strap_done && !is_mii && !two_clock_mode && clock_out_eff
        |-> txclk_oe && (txclk_o == clk125_s)) else $error("125 clock not out");
    a_mii_100_rate: assert property (($changed(mii_clk) && !speed_10 && !port_role_select && is_mii) ##1
        (!speed_10 && !port_role_select && is_mii) |-> !$changed(mii_clk) ##1 $changed(mii_clk))
        else $error("mii 100 clock rate wrong");
    a_gmii_capture: assert property (gmii_take |=> tx_valid && tx_data == $past(txd_s))
        else $error("gmii byte lost");
    a_rgmii_byte: assert property (rgmii_high |=> tx_valid && tx_data == {$past(txd_s[3:0]), $past(low_nibble)})
        else $error("rgmii byte wrong");

    c_gmii_byte: cover property (gmii_take ##1 tx_valid);
    c_rgmii_byte: cover property (rgmii_low ##[1:40] rgmii_high);
    c_two_clock_comma: cover property (two_clock_mode && rx_fall && rx_comma_s);
    c_dce_clock: cover property (is_mii && !port_role_select && $rose(mii_clk));
endmodule

//--- rtl/ppcfg_pkg.sv
package ppcfg_pkg;

    // =======================================================
    // register map
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] ADDR_BASIC_MODE_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_PARALLEL_PORT_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_TX_DATA = 8'h0c;

    localparam int BMC_LOOPBACK_BIT = 0;
    localparam int BMC_COL_TEST_BIT = 1;

    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_MODE_W = 3;
    localparam int CFG_TWO_CLOCK_BIT = 4;
    localparam int CFG_CLOCK_OUT_BIT = 5;
    localparam int CFG_ROLE_BIT = 6;
    localparam int CFG_SPEED10_BIT = 7;

    localparam int ST_COL_BIT = 0;
    localparam int ST_CRS_BIT = 1;
    localparam int ST_STRAP_LSB = 2;
    localparam int ST_TXCLK_IN_BIT = 6;
    localparam int ST_TWO_CLOCK_BIT = 7;

    localparam logic [2:0] MODE_MII = 3'h0;
    localparam logic [2:0] MODE_GMII = 3'h1;
    localparam logic [2:0] MODE_RGMII = 3'h2;
    localparam logic [2:0] MODE_TBI = 3'h3;
    localparam logic [2:0] MODE_RTBI = 3'h4;

    localparam logic [2:0] MODE_RESET = MODE_MII;
    localparam logic RESET_OFF = 1'b0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // =======================================================
    // timing
    localparam int CLK_FREQ_KHZ = 100000;
    localparam int MII_100_FREQ_KHZ = 25000;
    localparam int MII_10_FREQ_KHZ = 2500;
    localparam int HALF_100_CYCLES = CLK_FREQ_KHZ / (2 * MII_100_FREQ_KHZ);
    localparam int HALF_10_CYCLES = CLK_FREQ_KHZ / (2 * MII_10_FREQ_KHZ);
    localparam int DIV_W = 5;

endpackage

//--- rtl/sync2.sv
`timescale 1ns/1ps
// =======================================================
// two-flop synchroniser
// no reset: strap pins must keep being sampled while reset is low
module sync2 #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge aclk)
    begin
        stage1 <= async_in;
        sync_out <= stage1;
    end
endmodule

//--- verification/mac_side_model.sv
`timescale 1ns/1ps
module mac_side_model (
    output logic gtxclk,
    output logic [7:0] txd,
    output logic rx_clock,
    output logic ref_clock_125
);
    // =======================================================
    // free-running clocks, phase unrelated to aclk
    initial
    begin
        ref_clock_125 = 1'b0;
        forever #4 ref_clock_125 = ~ref_clock_125;
    end

    initial
    begin
        rx_clock = 1'b0;
        #37;
        forever #80 rx_clock = ~rx_clock;
    end

    // =======================================================
    // transmit link: clock parked low between transfers
    initial
    begin
        gtxclk = 1'b0;
        txd = 8'h00;
    end

    // ddr puts the high nibble on the low four lines before the fall
    task automatic send_byte(input logic [7:0] b, input bit ddr);
        // start off the aclk edges so the pin samplers never race the model
        #2 txd = b;
        #40 gtxclk = 1'b1;
        #40 if (ddr) txd[3:0] = b[7:4];
        #40 gtxclk = 1'b0;
        // stale data must not look valid once the edge is past
        #40 txd = ~txd;
    endtask
endmodule

//--- verification/parallel_port_status_tb_top.sv
`timescale 1ns/1ps
module parallel_port_status_tb_top
    import ppcfg_pkg::*;
;
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr, txd, tx_data;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic tx_active, rx_active, collision, rx_comma, rx_clock, ref_clock_125, gtxclk, tx_valid;
    logic col_o, col_oe, crs_o, crs_oe, txclk_o, txclk_oe;
    logic col_strap, crs_strap, rx_dv_i, txclk_drv;
    int err_total, compares;
    // each shared pin resolves to whoever enables it
    wire col_pin = col_oe ? col_o : col_strap;
    wire crs_pin = crs_oe ? crs_o : crs_strap;
    wire txclk_pin = txclk_oe ? txclk_o : txclk_drv;

    parallel_port_status dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .tx_active, .rx_active, .collision, .rx_comma, .rx_clock, .ref_clock_125,
        .col_i(col_pin), .col_o, .col_oe, .crs_i(crs_pin), .crs_o, .crs_oe, .rx_dv_i,
        .txclk_i(txclk_pin), .txclk_o, .txclk_oe, .gtxclk, .txd, .tx_data, .tx_valid
    );

    mac_side_model mac (.gtxclk, .txd, .rx_clock, .ref_clock_125);

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // =======================================================
    // reporting
    task automatic report_and_stop();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hang(input string what);
        err_total++;
        $display("unexpected %s: expected an answer seen none", what);
        report_and_stop();
    endtask

    // =======================================================
    // register bus
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 40);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (s_axi_bvalid !== 1'b1) hang("write response");
    endtask

    task automatic axi_read(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 40);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (s_axi_rvalid !== 1'b1) hang("read data");
    endtask

    // =======================================================
    // pin helpers
    task automatic clk_period(input int exp);
        int n, t, rises;
        logic prev;
        n = 0;
        t = 0;
        rises = 0;
        prev = txclk_o;
        while (rises < 2 && t < 200)
        begin
            @(posedge aclk);
            t++;
            if (txclk_o && !prev) rises++;
            if (rises > 0) n++;
            prev = txclk_o;
        end
        if (rises < 2)
            hang("txclk edges");
        else
            chk("txclk period", exp, n - 1);
    endtask

    // sampled at aclk, so the rise is seen up to one cycle late
    task automatic rx_rise();
        int n;
        n = 0;
        while (rx_clock !== 1'b0 && n < 40) @(posedge aclk) n++;
        while (rx_clock !== 1'b1 && n < 40) @(posedge aclk) n++;
        if (n == 40) hang("rx clock edge");
    endtask

    task automatic cap(input logic [7:0] b, input bit ddr);
        int n;
        logic [7:0] got;
        n = 0;
        fork
            mac.send_byte(b, ddr);
            begin
                do @(posedge aclk) n++; while (!tx_valid && n < 60);
                got = tx_data;
            end
        join
        if (n == 60)
            hang("tx_valid");
        else
            chk("tx_data", b, got);
    endtask

    // =======================================================
    // tests
    initial
    begin
        err_total = 0;
        compares = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        {tx_active, rx_active, collision, rx_comma} = 4'h0;
        {col_strap, crs_strap, rx_dv_i, txclk_drv} = 4'h8;
        repeat (10) @(posedge aclk);
        chk("col_oe in reset", 1'b0, col_oe);
        chk("crs_oe in reset", 1'b0, crs_oe);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("col_oe", 1'b1, col_oe);
        chk("crs_oe", 1'b1, crs_oe);
        // txclk level bit masked: the pin toggles in the default role
        axi_read(ADDR_STATUS);
        chk("straps", 32'h04, rd & 32'hbf);
        axi_read(ADDR_BASIC_MODE_CONTROL);
        chk("mode control", 32'h0, rd);
        axi_read(ADDR_PARALLEL_PORT_CONFIG);
        chk("port config", 32'h0, rd);
        axi_read(8'h40);
        chk("unmapped resp", RESP_SLVERR, rs);
        $display("test reset done");

        collision <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("col", 1'b1, col_o);
        axi_write(ADDR_BASIC_MODE_CONTROL, 32'h1);
        chk("write resp", RESP_OKAY, rs);
        repeat (3) @(posedge aclk);
        chk("col in loopback", 1'b0, col_o);
        axi_write(ADDR_BASIC_MODE_CONTROL, 32'h0);
        collision <= 1'b0;
        tx_active <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("crs tx", 1'b1, crs_o);
        chk("col idle", 1'b0, col_o);
        tx_active <= 1'b0;
        rx_active <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("crs rx", 1'b1, crs_o);
        rx_active <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("crs idle", 1'b0, crs_o);
        $display("test status pins done");

        chk("dce txclk_oe", 1'b1, txclk_oe);
        clk_period(2 * HALF_100_CYCLES);
        axi_write(ADDR_PARALLEL_PORT_CONFIG, 32'h80);
        clk_period(2 * HALF_10_CYCLES);
        axi_write(ADDR_PARALLEL_PORT_CONFIG, 32'h40);
        txclk_drv <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("dte txclk_oe", 1'b0, txclk_oe);
        axi_read(ADDR_STATUS);
        chk("dte clock level", 1'b1, rd[ST_TXCLK_IN_BIT]);
        $display("test mii clock done");

        axi_write(ADDR_PARALLEL_PORT_CONFIG, {29'h0, MODE_GMII});
        repeat (3) @(posedge aclk);
        chk("gmii txclk_oe off", 1'b0, txclk_oe);
        chk("gmii col_oe", 1'b1, col_oe);
        axi_write(ADDR_PARALLEL_PORT_CONFIG, {26'h0, 1'b1, 2'h0, MODE_GMII});
        repeat (3) @(posedge aclk);
        chk("gmii txclk_oe on", 1'b1, txclk_oe);
        cap(8'h5a, 1'b0);
        cap(8'ha5, 1'b0);
        axi_read(ADDR_TX_DATA);
        chk("tx data reg", 32'ha5, rd);
        axi_write(ADDR_PARALLEL_PORT_CONFIG, {29'h0, MODE_RGMII});
        cap(8'h3c, 1'b1);
        cap(8'hc3, 1'b1);
        $display("test transmit capture done");

        for (int two = 0; two < 2; two++)
        begin
            axi_write(ADDR_PARALLEL_PORT_CONFIG, {27'h0, two[0], 1'b0, MODE_TBI});
            repeat (40) @(posedge aclk);
            chk("tbi col_oe", 1'b0, col_oe);
            chk("tbi txclk_oe", two[0], txclk_oe);
            for (int v = 1; v >= 0; v--)
            begin
                rx_rise();
                repeat (4) @(posedge aclk);
                if (two == 1) chk("second rx clock", 1'b0, txclk_o);
                rx_comma <= v[0];
                repeat (10) @(posedge aclk);
                chk("comma after fall", two[0] ? v[0] : !v[0], crs_o);
                repeat (12) @(posedge aclk);
                chk("comma", v[0], crs_o);
            end
        end
        axi_write(ADDR_PARALLEL_PORT_CONFIG, {26'h0, 1'b1, 2'h0, MODE_RTBI});
        repeat (3) @(posedge aclk);
        chk("rtbi txclk_oe", 1'b1, txclk_oe);
        chk("rtbi col_oe", 1'b0, col_oe);
        $display("test ten-bit modes done");

        // second reset: rx_dv strap high picks the two-clock option, txclk strap high the clock output
        rx_dv_i <= 1'b1;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rx_dv_i <= 1'b0;
        repeat (3) @(posedge aclk);
        axi_read(ADDR_STATUS);
        chk("straps after second reset", 32'hb4, rd & 32'hbf);
        $display("test strap reset done");
        report_and_stop();
    end
endmodule
